// [src/sfis_core.sv]
`timescale 1ns/1ps
`default_nettype none
module sfis_core
	import sfis_pkg::*;
(
	input  wire logic                sck,
	input  wire logic                ref_clk,
	input  wire logic                resetn,
	input  wire logic                vcc_off,
	input  wire logic                vcc_cutoff,
	input  wire logic                vcc_min_ok,
	input  wire logic                reset_pin_en,
	input  wire logic [7:0]          volatile_status_one,
	input  wire logic [7:0]          volatile_config_one,
	input  wire logic                cs_n,
	input  wire logic [3:0]          io_in,
	output var  logic [3:0]          io_out,
	output var  logic [3:0]          io_oe,
	input  wire logic                cmd_done,
	input  wire sfis_pkg::sfis_phase_t next_phase,
	input  wire sfis_pkg::sfis_width_t next_width,
	input  wire logic [3:0]          rd_data,
	output var  logic [7:0]          opcode,
	output var  logic                opcode_valid,
	output var  logic                prog_erase_allow,
	output var  logic                deep_sleep_state,
	output var  logic                ready
);
	import sfis_pkg::*;

	// ---------------- reference clock domain -----------------
	logic cs_n_s;
	logic rst_io_s;
	logic vcc_off_s;
	logic vcc_cut_s;
	logic vcc_min_s;

	sfis_sync3 #(.RST_VAL(1'b1)) u_sync_cs (
		.clk(ref_clk), .rst_n(resetn), .d(cs_n), .q(cs_n_s));
	sfis_sync3 #(.RST_VAL(1'b1)) u_sync_rst (
		.clk(ref_clk), .rst_n(resetn), .d(io_in[3]), .q(rst_io_s));
	sfis_sync3 #(.RST_VAL(1'b1)) u_sync_off (
		.clk(ref_clk), .rst_n(resetn), .d(vcc_off), .q(vcc_off_s));
	sfis_sync3 #(.RST_VAL(1'b1)) u_sync_cut (
		.clk(ref_clk), .rst_n(resetn), .d(vcc_cutoff), .q(vcc_cut_s));
	sfis_sync3 #(.RST_VAL(1'b0)) u_sync_min (
		.clk(ref_clk), .rst_n(resetn), .d(vcc_min_ok), .q(vcc_min_s));

	sfis_dev_t        dev_r;
	sfis_dev_t        dev_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] off_cnt_r;
	logic [TMR_W-1:0] rp_cnt_r;
	logic [TMR_W-1:0] rh_cnt_r;
	logic             off_long_r;
	logic             quad_mode;
	logic             reset_sense;
	logic             reset_fire;

	assign quad_mode = volatile_config_one[QUAD_BIT];

	// IO3 acts as reset only when not in quad, or in quad with select high
	assign reset_sense = reset_pin_en && (!quad_mode || cs_n_s);

	// pulse-width filter on the shared reset pin
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rp_cnt_r <= '0;
		end else if (reset_sense && !rst_io_s) begin
			if (rp_cnt_r != TMR_W'(RESET_PULSE_TIME_CYC))
				rp_cnt_r <= rp_cnt_r + 1'b1;
		end else begin
			rp_cnt_r <= '0;
		end
	end

	assign reset_fire = (rp_cnt_r == TMR_W'(RESET_PULSE_TIME_CYC));

	// time since reset pin rose, saturating at hold time
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rh_cnt_r <= '0;
		end else if (!rst_io_s) begin
			rh_cnt_r <= '0;
		end else if (rh_cnt_r != TMR_W'(RESET_HOLD_TIME_CYC)) begin
			rh_cnt_r <= rh_cnt_r + 1'b1;
		end
	end

	// how long the supply has stayed at power-off level
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			off_cnt_r  <= '0;
			off_long_r <= 1'b0;
		end else if (vcc_off_s) begin
			if (off_cnt_r != TMR_W'(POWER_DOWN_INTERVAL_CYC))
				off_cnt_r <= off_cnt_r + 1'b1;
			else
				off_long_r <= 1'b1;
		end else begin
			off_cnt_r <= '0;
			if (dev_r == SFIS_COLD)
				off_long_r <= 1'b0;
		end
	end

	// decoded opcode arriving from the link domain
	logic [7:0] op_x_r;
	logic       op_tgl_s;
	logic       op_tgl_q_r;
	logic       op_evt;
	logic       sleep_req;
	logic       wake_req;

	assign op_evt    = op_tgl_s ^ op_tgl_q_r;
	assign sleep_req = op_evt && (op_x_r == SLEEP_OPCODE);
	assign wake_req  = op_evt && (op_x_r == WAKE_OPCODE);

	always_comb begin
		dev_nxt = dev_r;
		unique case (dev_r)
			SFIS_OFF: begin
				if (!vcc_off_s && vcc_min_s && off_long_r)
					dev_nxt = SFIS_COLD;
			end
			SFIS_LOWV: begin
				if (!vcc_cut_s)
					dev_nxt = SFIS_READY;
			end
			SFIS_COLD: begin
				if (tmr_r == '0)
					dev_nxt = SFIS_READY;
			end
			SFIS_WARM: begin
				if (tmr_r == '0 && rh_cnt_r == TMR_W'(RESET_HOLD_TIME_CYC))
					dev_nxt = SFIS_READY;
			end
			SFIS_READY: begin
				if (reset_fire)
					dev_nxt = SFIS_WARM;
				else if (sleep_req && !volatile_status_one[OIP_BIT])
					dev_nxt = SFIS_SLEEP;
			end
			SFIS_SLEEP: begin
				if (reset_fire)
					dev_nxt = SFIS_WARM;
				else if (tmr_r == TMR_W'(1))
					dev_nxt = SFIS_READY;
			end
			default: dev_nxt = SFIS_OFF;
		endcase
		// power-off overrides everything else; cutoff overrides every state but off and cold
		if (vcc_off_s)
			dev_nxt = SFIS_OFF;
		else if (vcc_cut_s && dev_r != SFIS_OFF && dev_r != SFIS_COLD)
			dev_nxt = SFIS_LOWV;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			dev_r <= SFIS_OFF;
		else
			dev_r <= dev_nxt;
	end

	// shared down-counter for powerup wait, reset process and wake delay
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_r <= '0;
		end else if (dev_r != SFIS_COLD && dev_nxt == SFIS_COLD) begin
			tmr_r <= TMR_W'(POWERUP_WAIT_CYC);
		end else if (dev_r != SFIS_WARM && dev_nxt == SFIS_WARM) begin
			tmr_r <= TMR_W'(RESET_PROCESS_TIME_CYC);
		end else if (dev_r == SFIS_SLEEP && wake_req && tmr_r == '0) begin
			tmr_r <= TMR_W'(WAKE_DELAY_CYC + 1);
		end else if (tmr_r > TMR_W'(1) || (tmr_r == TMR_W'(1) && dev_r != SFIS_SLEEP)) begin
			tmr_r <= tmr_r - 1'b1;
		end else if (dev_r == SFIS_SLEEP && tmr_r == TMR_W'(1)) begin
			tmr_r <= '0;
		end
	end

	assign ready            = (dev_r == SFIS_READY);
	assign deep_sleep_state = (dev_r == SFIS_SLEEP);
	assign prog_erase_allow = (dev_r == SFIS_READY) && !vcc_cut_s;

	// level crossing of the interface enable into the link domain
	logic             en_src;
	logic             en_lk;
	logic             sleep_lk;

	assign en_src = ready || deep_sleep_state;

	// ---------------- link clock domain ----------------------
	// sck stops between frames, so select high is taken as an async reset
	logic             frame_rst_n;
	assign frame_rst_n = resetn && !cs_n;

	// sck stops between frames, so these are stale early in a frame; read only at bit eight
	sfis_sync3 #(.RST_VAL(1'b0)) u_sync_en (
		.clk(sck), .rst_n(resetn), .d(en_src), .q(en_lk));
	sfis_sync3 #(.RST_VAL(1'b0)) u_sync_sleep (
		.clk(sck), .rst_n(resetn), .d(deep_sleep_state), .q(sleep_lk));

	sfis_phase_t      ph_r;
	sfis_width_t      wid_r;
	logic [2:0]       bit_cnt_r;
	logic [7:0]       sh_r;
	logic [7:0]       op_l_r;
	logic             op_tgl_r;

	// instruction shift: phases beyond it follow the command decoder
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			ph_r      <= SFIS_PH_IDLE;
			wid_r     <= SFIS_W_SINGLE;
			bit_cnt_r <= '0;
			sh_r      <= '0;
		end else begin
			unique case (ph_r)
				SFIS_PH_IDLE: begin
					// first edge after select falls carries instruction msb
					ph_r      <= SFIS_PH_INSTR;
					sh_r      <= {sh_r[6:0], io_in[0]};
					bit_cnt_r <= 3'd1;
				end
				SFIS_PH_INSTR: begin
					sh_r      <= {sh_r[6:0], io_in[0]};
					bit_cnt_r <= bit_cnt_r + 3'd1;
					// a device that is not up never leaves the instruction phase, so never drives
					if (bit_cnt_r == 3'd7 && en_lk && !sleep_lk && !cmd_done) begin
						ph_r  <= next_phase;
						wid_r <= next_width;
					end
				end
				SFIS_PH_IN, SFIS_PH_LAT: begin
					// latency lines are never sampled here
					if (cmd_done) begin
						ph_r  <= next_phase;
						wid_r <= next_width;
					end
				end
				SFIS_PH_OUT: begin
					ph_r <= SFIS_PH_OUT;
				end
			endcase
		end
	end

	// completed opcode handed over by toggle
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			op_l_r   <= '0;
			op_tgl_r <= 1'b0;
		end else if (ph_r == SFIS_PH_INSTR && bit_cnt_r == 3'd7) begin
			op_l_r   <= {sh_r[6:0], io_in[0]};
			op_tgl_r <= ~op_tgl_r;
		end
	end

	sfis_sync3 #(.RST_VAL(1'b0)) u_sync_tgl (
		.clk(ref_clk), .rst_n(resetn), .d(op_tgl_r), .q(op_tgl_s));

	// opcode word is stable long before its toggle settles
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			op_tgl_q_r   <= 1'b0;
			op_x_r       <= '0;
			opcode       <= '0;
			opcode_valid <= 1'b0;
		end else begin
			op_tgl_q_r   <= op_tgl_s;
			op_x_r       <= op_l_r;
			opcode_valid <= op_evt && ready;
			if (op_evt && ready)
				opcode <= op_x_r;
		end
	end

	// output drive, launched on the falling edge
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			io_out <= '0;
			io_oe  <= '0;
		end else if (ph_r == SFIS_PH_OUT) begin
			unique case (wid_r)
				SFIS_W_SINGLE: begin
					io_oe  <= 4'h2;
					io_out <= {2'b00, rd_data[0], 1'b0};
				end
				SFIS_W_DUAL: begin
					io_oe  <= 4'h3;
					io_out <= {2'b00, rd_data[1:0]};
				end
				SFIS_W_QUAD, SFIS_W_DDR: begin
					io_oe  <= 4'hF;
					io_out <= rd_data;
				end
			endcase
		end else begin
			io_oe  <= '0;
			io_out <= '0;
		end
	end

	a_sleep_needs_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		(dev_r == SFIS_READY && dev_nxt == SFIS_SLEEP) |-> !volatile_status_one[OIP_BIT])
		else $error("deep sleep entered during an embedded operation");
	a_off_no_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		vcc_off_s |=> (dev_r == SFIS_OFF && !prog_erase_allow))
		else $error("device active while supply off");
	a_cold_ends_ready: assert property (@(posedge ref_clk) disable iff (!resetn)
		(dev_r == SFIS_COLD && tmr_r == '0 && !vcc_off_s && !vcc_cut_s) |=> ready)
		else $error("cold start did not finish into standby");
	a_warm_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		(dev_r == SFIS_WARM && rh_cnt_r != TMR_W'(RESET_HOLD_TIME_CYC)) |=> !ready)
		else $error("warm reset left before hold time");
	a_float_idle: assert property (@(posedge sck) disable iff (!frame_rst_n)
		(ph_r != SFIS_PH_OUT) |=> (ph_r == SFIS_PH_OUT) || (io_oe == 4'h0))
		else $error("pins driven outside output phase");
	a_cmd_blocked: assert property (@(posedge ref_clk) disable iff (!resetn)
		opcode_valid |-> $past(ready))
		else $error("command passed while not ready");
	a_reset_fire: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reset_fire && ready && !vcc_off_s && !vcc_cut_s) |=> dev_r == SFIS_WARM)
		else $error("reset pulse ignored");
	a_quad_reset_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
		(quad_mode && !cs_n_s) |-> rp_cnt_r == '0 || $past(cs_n_s))
		else $error("quad reset sensed with select low");
endmodule
`default_nettype wire

// [src/sfis_pkg.sv]
package sfis_pkg;

	// opcodes seen at the interface
	localparam logic [7:0] SLEEP_OPCODE = 8'hB9;
	localparam logic [7:0] WAKE_OPCODE  = 8'hAB;

	// bit positions in the volatile registers
	localparam int OIP_BIT  = 0;
	localparam int QUAD_BIT = 1;

	// reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST = 8'h00;

	// reference clock
	localparam int CLK_MHZ = 25;

	// times in microseconds
	localparam int POWERUP_WAIT_US         = 300;
	localparam int POWER_DOWN_INTERVAL_US  = 10;
	localparam int RESET_PULSE_TIME_US     = 1;
	localparam int RESET_PROCESS_TIME_US   = 35;
	localparam int RESET_HOLD_TIME_US      = 1;
	localparam int WAKE_DELAY_US           = 30;

	// least times round up; products are exact in whole cycles here
	localparam int POWERUP_WAIT_CYC        = POWERUP_WAIT_US * CLK_MHZ;
	localparam int POWER_DOWN_INTERVAL_CYC = POWER_DOWN_INTERVAL_US * CLK_MHZ;
	localparam int RESET_PULSE_TIME_CYC    = RESET_PULSE_TIME_US * CLK_MHZ;
	localparam int RESET_PROCESS_TIME_CYC  = RESET_PROCESS_TIME_US * CLK_MHZ;
	localparam int RESET_HOLD_TIME_CYC     = RESET_HOLD_TIME_US * CLK_MHZ;
	localparam int WAKE_DELAY_CYC          = WAKE_DELAY_US * CLK_MHZ;

	localparam int TMR_W = 16;

	// device-level states
	typedef enum logic [5:0] {
		SFIS_OFF    = 6'b000001,
		SFIS_LOWV   = 6'b000010,
		SFIS_COLD   = 6'b000100,
		SFIS_WARM   = 6'b001000,
		SFIS_READY  = 6'b010000,
		SFIS_SLEEP  = 6'b100000
	} sfis_dev_t;

	// link-side pin phases
	typedef enum logic [4:0] {
		SFIS_PH_IDLE  = 5'b00001,
		SFIS_PH_INSTR = 5'b00010,
		SFIS_PH_IN    = 5'b00100,
		SFIS_PH_LAT   = 5'b01000,
		SFIS_PH_OUT   = 5'b10000
	} sfis_phase_t;

	// transfer widths
	typedef enum logic [3:0] {
		SFIS_W_SINGLE = 4'b0001,
		SFIS_W_DUAL   = 4'b0010,
		SFIS_W_QUAD   = 4'b0100,
		SFIS_W_DDR    = 4'b1000
	} sfis_width_t;

endpackage

// [src/sfis_sync3.sv]
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module sfis_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output var  logic q
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RST_VAL;
		end else if (s2_r == s3_r) begin
			q <= s3_r;
		end
	end
endmodule
`default_nettype wire

// [test/sfis_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module sfis_core_tb;
	import sfis_pkg::*;

	logic                  ref_clk;
	logic                  resetn;
	logic                  vcc_off;
	logic                  vcc_cutoff;
	logic                  vcc_min_ok;
	logic                  reset_pin_en;
	logic [7:0]            status;
	logic [7:0]            config_r;
	logic [3:0]            rd_data;
	logic                  sck;
	logic                  cs_n;
	logic [3:0]            io_in;
	logic [3:0]            io_out;
	logic [3:0]            io_oe;
	logic                  cmd_done;
	sfis_phase_t           next_phase;
	sfis_width_t           next_width;
	logic [7:0]            opcode;
	logic                  opcode_valid;
	logic                  prog_erase_allow;
	logic                  deep_sleep_state;
	logic                  ready;
	int                    fail_count = 0;
	int                    checked = 0;
	int                    vcount = 0;

	sfis_core sfis_core_i (.sck(sck), .ref_clk(ref_clk), .resetn(resetn), .vcc_off(vcc_off),
		.vcc_cutoff(vcc_cutoff), .vcc_min_ok(vcc_min_ok), .reset_pin_en(reset_pin_en),
		.volatile_status_one(status), .volatile_config_one(config_r), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .cmd_done(cmd_done),
		.next_phase(next_phase), .next_width(next_width), .rd_data(rd_data), .opcode(opcode),
		.opcode_valid(opcode_valid), .prog_erase_allow(prog_erase_allow),
		.deep_sleep_state(deep_sleep_state), .ready(ready));

	sfis_host sfis_host_i (.sck(sck), .cs_n(cs_n), .io_in(io_in), .dev_out(io_out),
		.dev_oe(io_oe), .cmd_done(cmd_done), .next_phase(next_phase), .next_width(next_width));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// one-cycle pulses are counted so no check can miss them
	always @(posedge ref_clk) begin
		if (opcode_valid === 1'b1) begin
			vcount <= vcount + 1;
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && ready !== 1'b1; i++) begin
			@(posedge ref_clk);
		end
	endtask

	task automatic send(input logic [7:0] op);
		sfis_host_i.frame(op, SFIS_PH_IDLE, SFIS_W_SINGLE, 0);
		sfis_host_i.stop();
		cyc(12);
	endtask

	task automatic t_power_up();
		int v0;
		cyc(5);
		check({7'h00, prog_erase_allow}, 8'h00);
		v0 = vcount;
		send(8'hC3);
		check(8'(vcount - v0), 8'h00);
		cyc(260);
		vcc_off <= 1'b0;
		vcc_cutoff <= 1'b0;
		vcc_min_ok <= 1'b1;
		cyc(7000);
		check({3'h0, ready, io_oe}, 8'h00);
		wait_ready(1000);
		check({7'h00, ready}, 8'h01);
	endtask

	task automatic t_command();
		int v0;
		v0 = vcount;
		sfis_host_i.frame(8'hC3, SFIS_PH_IDLE, SFIS_W_SINGLE, 0);
		check({4'h0, io_oe}, 8'h00);
		sfis_host_i.stop();
		cyc(12);
		check(8'(vcount - v0), 8'h01);
		check(opcode, 8'hC3);
		sfis_host_i.idle_noise();
		cyc(12);
		check(8'(vcount - v0), 8'h01);
	endtask

	task automatic t_cutoff();
		int v0;
		vcc_cutoff <= 1'b1;
		cyc(5);
		check({7'h00, prog_erase_allow}, 8'h00);
		v0 = vcount;
		send(8'h3C);
		check(8'(vcount - v0), 8'h00);
		sfis_host_i.frame(8'h0B, SFIS_PH_OUT, SFIS_W_QUAD, 3);
		check({4'h0, io_oe}, 8'h00);
		sfis_host_i.stop();
		cyc(2);
		vcc_cutoff <= 1'b0;
		cyc(5);
	endtask

	task automatic t_phases();
		sfis_phase_t p;
		sfis_width_t w;
		logic [3:0] exp;
		logic [3:0] eout;
		logic [3:0] eo;
		for (int k = 0; k < 12; k++) begin
			w = sfis_width_t'(4'b0001 << (k / 3));
			p = sfis_phase_t'(5'b00100 << (k % 3));
			eo = (k < 3) ? 4'h2 : (k < 6) ? 4'h3 : 4'hF;
			exp = (p != SFIS_PH_OUT) ? 4'h0 : eo;
			eout = (k < 3) ? {2'b00, rd_data[0], 1'b0} : (k < 6) ? {2'b00, rd_data[1:0]} : rd_data;
			sfis_host_i.frame(8'h0B, p, w, 5);
			@(posedge ref_clk);
			check({4'h0, io_oe}, {4'h0, exp});
			check({4'h0, io_out & exp}, {4'h0, eout & exp});
			if (p != SFIS_PH_OUT) begin
				sfis_host_i.advance();
				@(posedge ref_clk);
				check({4'h0, io_oe}, {4'h0, eo});
			end
			sfis_host_i.stop();
			cyc(5);
			check({4'h0, io_oe}, 8'h00);
		end
	endtask

	task automatic t_sleep();
		int v0;
		status <= 8'h01;
		send(SLEEP_OPCODE);
		check({7'h00, deep_sleep_state}, 8'h00);
		status <= 8'h00;
		send(SLEEP_OPCODE);
		check({7'h00, deep_sleep_state}, 8'h01);
		v0 = vcount;
		send(8'hC3);
		check(8'(vcount - v0), 8'h00);
		send(WAKE_OPCODE);
		cyc(690);
		check({7'h00, deep_sleep_state}, 8'h01);
		wait_ready(120);
		check({6'h00, deep_sleep_state, ready}, 8'h01);
		v0 = vcount;
		send(8'hC3);
		check(8'(vcount - v0), 8'h01);
	endtask

	task automatic t_warm();
		@(posedge ref_clk);
		reset_pin_en <= 1'b1;
		sfis_host_i.reset_pulse(1200, 1'b0);
		cyc(800);
		check({7'h00, ready}, 8'h00);
		wait_ready(200);
		check({7'h00, ready}, 8'h01);
		sfis_host_i.reset_pulse(40000, 1'b0);
		cyc(10);
		check({7'h00, ready}, 8'h00);
		wait_ready(100);
		check({7'h00, ready}, 8'h01);
		config_r <= 8'h02;
		sfis_host_i.reset_pulse(1200, 1'b1);
		cyc(30);
		check({7'h00, ready}, 8'h01);
		sfis_host_i.reset_pulse(1200, 1'b0);
		cyc(5);
		check({7'h00, ready}, 8'h00);
		wait_ready(1000);
		reset_pin_en <= 1'b0;
		config_r <= 8'h00;
		sfis_host_i.reset_pulse(1200, 1'b0);
		cyc(5);
		check({7'h00, ready}, 8'h01);
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		fail_count++;
		wrap_up();
	end

	initial begin
		resetn = 1'b0;
		vcc_off = 1'b1;
		vcc_cutoff = 1'b1;
		vcc_min_ok = 1'b0;
		reset_pin_en = 1'b0;
		status = 8'h00;
		config_r = 8'h00;
		rd_data = 4'h5;
		cyc(3);
		resetn <= 1'b1;
		t_power_up();
		t_command();
		t_cutoff();
		t_phases();
		t_sleep();
		t_warm();
		wrap_up();
	end
endmodule
`default_nettype wire

// [test/sfis_host.sv]
`timescale 1ns/1ps
`default_nettype none
// host controller model; sck runs inside frames and during idle_noise, released lines wander
module sfis_host
	import sfis_pkg::*;
(
	output var  logic                  sck,
	output var  logic                  cs_n,
	output var  logic [3:0]            io_in,
	input  wire logic [3:0]            dev_out,
	input  wire logic [3:0]            dev_oe,
	output var  logic                  cmd_done,
	output var  sfis_pkg::sfis_phase_t next_phase,
	output var  sfis_pkg::sfis_width_t next_width
);
	logic [3:0] drv;
	logic [3:0] drv_oe;
	logic       float_pat;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		drv = 4'hF;
		drv_oe = 4'hC;
		cmd_done = 1'b0;
		next_phase = SFIS_PH_IDLE;
		next_width = SFIS_W_SINGLE;
		float_pat = 1'b0;
		forever #5 float_pat = ~float_pat;
	end

	// an undriven line must not settle to a convenient level
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			io_in[i] = dev_oe[i] ? dev_out[i] : drv_oe[i] ? drv[i] : float_pat ^ i[0];
		end
	end

	task automatic tick();
		#3 sck = 1'b1;
		#3 sck = 1'b0;
	endtask

	task automatic frame(input logic [7:0] op, input sfis_phase_t ph, input sfis_width_t w,
			input int n);
		cs_n = 1'b0;
		drv_oe = 4'hD;
		drv = 4'hC;
		next_phase = ph;
		next_width = w;
		for (int i = 7; i >= 0; i--) begin
			drv[0] = op[i];
			tick();
		end
		cmd_done = 1'b0;
		drv = 4'hA;
		if (ph == SFIS_PH_IN) begin
			drv_oe = (w == SFIS_W_SINGLE) ? 4'hD : 4'hF;
		end else if (ph != SFIS_PH_IDLE) begin
			drv_oe = (w inside {SFIS_W_SINGLE, SFIS_W_DUAL}) ? 4'h8 : 4'h0;
		end
		repeat (n) tick();
	endtask

	// decoder ends an input or latency phase; host lets go of the lines first
	task automatic advance();
		drv_oe = (next_width inside {SFIS_W_SINGLE, SFIS_W_DUAL}) ? 4'h8 : 4'h0;
		next_phase = SFIS_PH_OUT;
		cmd_done = 1'b1;
		tick();
		cmd_done = 1'b0;
		repeat (2) tick();
	endtask

	task automatic stop();
		cs_n = 1'b1;
		drv_oe = 4'hC;
		drv = 4'hF;
		next_phase = SFIS_PH_IDLE;
	endtask

	task automatic idle_noise();
		drv_oe = 4'hF;
		for (int i = 0; i < 8; i++) begin
			drv[0] = i[0];
			tick();
		end
		drv = 4'hF;
		drv_oe = 4'hC;
	endtask

	task automatic reset_pulse(input int ns, input logic keep_sel);
		cs_n = ~keep_sel;
		drv = 4'h7;
		#(ns);
		drv = 4'hF;
		#10;
		cs_n = 1'b1;
	endtask
endmodule
`default_nettype wire
